// [hdl/lv_hold_regs.svh]
// Constants for the low-voltage hold controller
`ifndef LV_HOLD_REGS_SVH
`define LV_HOLD_REGS_SVH
`define LV_SYNC_STAGES 2
`define LV_THRESH_MV 2100
`define LV_FILT_NS 20
`define LV_FILT_CYC ((`LV_FILT_NS + 4) / 5)
`endif

// [hdl/lv_hold_pkg.sv]
// Types for the low-voltage hold controller
package lv_hold_pkg;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_DRAIN = 4'h2,
		ST_HOLD = 4'h4,
		ST_WAKE = 4'h8
	} hold_state_e;
endpackage : lv_hold_pkg

// [hdl/lv_sync.sv]
// Multi-stage level synchroniser
`timescale 1ns/1ps
module lv_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Level in and out
	input wire logic i_async,
	output logic o_sync
);
	logic [STAGES-1:0] sync_r;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync_r <= '0;
		end else begin
			sync_r <= {sync_r[STAGES-2:0], i_async};
		end
	end

	assign o_sync = sync_r[STAGES-1];
endmodule : lv_sync

// [hdl/low_voltage_hold_control.sv]
// Low-voltage hold controller for the 4-bit core
`timescale 1ns/1ps
`include "lv_hold_regs.svh"

// Behaviour
// - A low indication (supply below 2.1 V) requests the hold state.
// - When the indication shows the supply back at 2.1 V the core resumes execution.
// - Hold is entered only at an instruction boundary, never mid-instruction.
// - The ring oscillator enable stays asserted in every state, hold included.
// - While held the state-update enable is low so latches, registers and SRAM keep contents.
module low_voltage_hold_control #(
	parameter int SYNC_STAGES = `LV_SYNC_STAGES
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Detector and core status
	input wire logic i_supply_low,
	input wire logic i_instr_done,
	// Core control
	output logic o_core_run,
	output logic o_state_we,
	output logic o_ring_oscillator_clock_en,
	output logic o_hold
);
	// State and output registers
	lv_hold_pkg::hold_state_e state_r;
	lv_hold_pkg::hold_state_e state_nxt;
	logic run_r;
	logic run_nxt;
	logic hold_r;
	logic hold_nxt;
	logic osc_r;
	logic osc_nxt;
	// Synchronised detector level and decoded conditions
	logic low_sync;
	logic in_run;
	logic in_drain;
	logic in_hold;
	logic in_wake;
	logic low_at_boundary;
	logic low_mid_instr;
	logic low_cleared;

	// Both held states freeze the core, so one decode serves outputs and checks
	function automatic logic held_state(input lv_hold_pkg::hold_state_e st);
		held_state = (st == lv_hold_pkg::ST_HOLD) || (st == lv_hold_pkg::ST_WAKE);
	endfunction : held_state

	// Detector output is asynchronous to the core clock
	lv_sync #(
		.STAGES(SYNC_STAGES)
	) u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_async(i_supply_low),
		.o_sync(low_sync)
	);

	assign in_run = (state_r == lv_hold_pkg::ST_RUN);
	assign in_drain = (state_r == lv_hold_pkg::ST_DRAIN);
	assign in_hold = (state_r == lv_hold_pkg::ST_HOLD);
	assign in_wake = (state_r == lv_hold_pkg::ST_WAKE);

	// Boundary is the cycle in which the running instruction completes
	assign low_at_boundary = low_sync && i_instr_done;
	assign low_mid_instr = low_sync && !i_instr_done;
	assign low_cleared = !low_sync;

	// Core keeps running during drain so the instruction can finish
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lv_hold_pkg::ST_RUN: begin
				if (low_at_boundary) begin
					state_nxt = lv_hold_pkg::ST_HOLD;
				end else if (low_mid_instr) begin
					state_nxt = lv_hold_pkg::ST_DRAIN;
				end
			end
			lv_hold_pkg::ST_DRAIN: begin
				// A low pulse that ends before the boundary is dropped
				if (low_cleared) begin
					state_nxt = lv_hold_pkg::ST_RUN;
				end else if (i_instr_done) begin
					state_nxt = lv_hold_pkg::ST_HOLD;
				end
			end
			lv_hold_pkg::ST_HOLD: begin
				if (low_cleared) begin
					state_nxt = lv_hold_pkg::ST_WAKE;
				end
			end
			lv_hold_pkg::ST_WAKE: begin
				// One extra clean sample before resume; a new low goes back to hold
				if (low_cleared) begin
					state_nxt = lv_hold_pkg::ST_RUN;
				end else begin
					state_nxt = lv_hold_pkg::ST_HOLD;
				end
			end
			default: begin
				state_nxt = lv_hold_pkg::ST_RUN;
			end
		endcase
	end

	assign hold_nxt = held_state(state_nxt);
	assign run_nxt = !hold_nxt;
	// Clock source is never gated here; hold only stops core run and state updates
	assign osc_nxt = 1'b1;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_r <= lv_hold_pkg::ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			run_r <= 1'b1;
		end else begin
			run_r <= run_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hold_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			osc_r <= 1'b1;
		end else begin
			osc_r <= osc_nxt;
		end
	end

	// Core run and state writes share one flop so they never disagree
	assign o_core_run = run_r;
	assign o_state_we = run_r;
	assign o_hold = hold_r;
	assign o_ring_oscillator_clock_en = osc_r;

	// Steps of entry and recovery used by the checks below
	sequence s_low_at_boundary;
		low_at_boundary && !in_hold;
	endsequence
	sequence s_low_mid_instr;
		low_mid_instr && in_run;
	endsequence
	sequence s_drain_boundary;
		in_drain && low_sync && i_instr_done;
	endsequence
	sequence s_sync_recovered;
		o_hold && !low_sync;
	endsequence
	sequence s_pin_recovered;
		o_hold && !i_supply_low;
	endsequence

	a_osc_always: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_ring_oscillator_clock_en)
		else $error("oscillator stopped");
	// Reset values are checked without the reset disable
	a_reset_values: assert property (@(posedge i_mclk)
		$fell(i_rst) |-> o_core_run && o_state_we && !o_hold && o_ring_oscillator_clock_en)
		else $error("wrong values after reset");

	a_hold_freeze: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_hold |-> !o_state_we && !o_core_run)
		else $error("state written in hold");
	a_we_tracks_run: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_state_we == o_core_run)
		else $error("write enable differs from run");
	a_hold_keeps: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_hold && low_sync |=> o_hold)
		else $error("hold left while supply low");

	a_enter_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_low_at_boundary |=> o_hold)
		else $error("no hold at boundary");
	a_hold_needs_low: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_hold) |-> $past(low_sync))
		else $error("hold without low supply");
	a_run_no_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_run && !low_sync |=> !o_hold)
		else $error("hold while supply good");

	a_no_mid_instr: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_hold) |-> $past(i_instr_done) || $past(state_r) == lv_hold_pkg::ST_HOLD)
		else $error("hold entered mid instruction");
	a_drain_runs: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_low_mid_instr |=> o_core_run && !o_hold)
		else $error("core stopped mid instruction");
	a_drain_then_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_low_mid_instr ##1 s_drain_boundary |=> o_hold)
		else $error("no hold after drain");

	a_resume_run: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_sync_recovered [*2] |=> o_core_run)
		else $error("no resume");
	// Bound assumes the default two synchroniser stages
	a_resume_bound: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_pin_recovered [*4] |=> o_core_run)
		else $error("resume too late");
	a_drain_cancel: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_drain && !low_sync |=> in_run && o_core_run)
		else $error("drain not cancelled");
	a_wake_brief: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_wake |=> !in_wake)
		else $error("wake state lingered");

	a_sync_delay: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(low_sync) |-> $past(i_supply_low, 2))
		else $error("sync too short");
endmodule : low_voltage_hold_control

// [tb/lv_detector_model.sv]
// Comparator model of the detector
`timescale 1ns/1ps
`include "lv_hold_regs.svh"
module lv_detector_model (
	// Supply level in millivolts
	input wire integer i_supply_mv,
	// Detector output
	output logic o_supply_low
);
	// Exactly at threshold counts as recovered
	assign o_supply_low = i_supply_mv < `LV_THRESH_MV;
endmodule : lv_detector_model

// [tb/low_voltage_hold_control_tb.sv]
// Random bench for the hold controller
`timescale 1ns/1ps
module low_voltage_hold_control_tb;
	logic i_mclk, i_rst, i_instr_done, low, o_core_run, o_state_we, o_osc, o_hold;
	int mv, seed, st, s1, s2, miscompares, compares, cyc;
	lv_detector_model i_det (.i_supply_mv(mv), .o_supply_low(low));
	low_voltage_hold_control i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_supply_low(low),
		.i_instr_done(i_instr_done), .o_core_run(o_core_run), .o_state_we(o_state_we),
		.o_ring_oscillator_clock_en(o_osc), .o_hold(o_hold));
	task check(input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task test_done;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	initial begin
		i_mclk = 0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// Reference: two-stage sync, then run/drain/hold/wake
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc > 4000) begin
			miscompares++;
			test_done;
		end
		if (i_rst) begin
			st = 0; s1 = 0; s2 = 0;
		end else begin
			case (st)
				0: st = s2 ? (i_instr_done ? 2 : 1) : 0;
				1: st = !s2 ? 0 : (i_instr_done ? 2 : 1);
				2: st = s2 ? 2 : 3;
				default: st = s2 ? 2 : 0;
			endcase
			s2 = s1; s1 = low;
		end
	end
	always @(negedge i_mclk) begin
		if (!i_rst) begin
			check(o_hold, st >= 2);
			check(o_core_run, st < 2);
			check(o_state_we, st < 2);
			check(o_osc, 1'b1);
		end
	end
	initial begin
		seed = 32'hCEDE8E6C; miscompares = 0; compares = 0; cyc = 0;
		i_rst = 1; mv = 2200; i_instr_done = 0;
		repeat (10) @(posedge i_mclk);
		#1 i_rst = 0;
		repeat (3000) begin
			@(posedge i_mclk);
			#1 i_instr_done = $random(seed);
			if (($random(seed) & 15) == 0) mv = 2096 + ($random(seed) & 7);
		end
		test_done;
	end
endmodule : low_voltage_hold_control_tb
